// File: logic/afecs_pkg.sv
/*
 * Constants, register map and helpers for the converter sequencer.
 * Assumes one 250 MHz clock; slower rates are enable pulses.
 */
package afecs_pkg;

    // timing
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned BASE_HZ = 32768;
    localparam int unsigned BASE_DIV = CLK_HZ / BASE_HZ;

    // processor register map
    localparam logic [15:0] ADDR_ACCUM = 16'h2001;
    localparam logic [15:0] ADDR_CHOP = 16'h2002;
    localparam logic [15:0] ADDR_CONV = 16'h2003;
    localparam logic [15:0] ADDR_CODE = 16'h2004;
    localparam logic [15:0] ADDR_BATT = 16'h2020;
    localparam logic [15:0] ADDR_DMEM_END = 16'h01FF;

    // field positions
    localparam int unsigned ACC_FS_LSB = 6;
    localparam int unsigned CHOP_LSB = 4;
    localparam int unsigned CONV_RES_BIT = 0;
    localparam int unsigned CONV_ALT_BIT = 1;
    localparam int unsigned CONV_PEND_BIT = 2;
    localparam int unsigned CONV_ALTRUN_BIT = 3;
    localparam int unsigned BATT_EN_BIT = 6;

    // reset values
    localparam logic [1:0] RST_CHOP = 2'h0;
    localparam logic RST_RES = 1'b1;
    localparam logic [1:0] RST_FS = 2'h0;
    localparam logic [5:0] RST_SS = 6'h32;
    localparam logic [4:0] RST_CODE = 5'h00;

    // chopper mode codes
    localparam logic [1:0] CHOP_POS = 2'h0;
    localparam logic [1:0] CHOP_REV = 2'h1;

    // engine data memory time slots
    localparam logic [1:0] SLOT_FILT = 2'h0;
    localparam logic [1:0] SLOT_MON = 2'h1;
    localparam logic [1:0] SLOT_CPU = 2'h2;

    // converter and memory geometry
    localparam int unsigned CONV_TICKS_NARROW = 2;
    localparam int unsigned CONV_TICKS_WIDE = 3;
    localparam int unsigned RESULT_SHIFT = 9;
    localparam int unsigned DMEM_WORDS = 128;
    localparam int unsigned DMEM_AW = 7;
    localparam int unsigned MON_WORDS = 4;
    localparam int unsigned MON_BITS = 35;
    localparam logic [6:0] WORD_TEMP = 7'h06;
    localparam logic [6:0] WORD_BATT = 7'h07;

    // first stage sample counts by code
    localparam logic [6:0] FS_N0 = 7'd42;
    localparam logic [6:0] FS_N1 = 7'd50;
    localparam logic [6:0] FS_N2 = 7'd84;
    localparam logic [6:0] FS_N3 = 7'd100;

    typedef enum logic [0:0] {AFECS_CONV, AFECS_SETTLE} afecs_seq_t;
    typedef enum logic [1:0] {AFECS_MIDLE, AFECS_MFETCH, AFECS_MLOAD, AFECS_MSHIFT} afecs_mon_t;

    function automatic logic [1:0] conv_ticks(input logic res);
        conv_ticks = res ? 2'(CONV_TICKS_WIDE) : 2'(CONV_TICKS_NARROW);
    endfunction

    // lsb-justified to 21 or 22 bits, then moved up by nine
    function automatic logic [31:0] place_result(input logic [21:0] d, input logic res);
        logic [31:0] w;
        w = {10'h000, d};
        if (!res)
            w[21] = 1'b0;
        place_result = w << RESULT_SHIFT;
    endfunction

    // memory word and input selection follow the same numbering
    function automatic logic [6:0] frame_word(input logic alt, input logic [1:0] st);
        frame_word = {5'h00, st};
        if (alt && st == 2'h0)
            frame_word = WORD_TEMP;
        else if (alt && st == 2'h3)
            frame_word = WORD_BATT;
    endfunction

    function automatic logic [6:0] first_stage_n(input logic [1:0] code);
        case (code)
            2'h0: first_stage_n = FS_N0;
            2'h1: first_stage_n = FS_N1;
            2'h2: first_stage_n = FS_N2;
            default: first_stage_n = FS_N3;
        endcase
    endfunction

endpackage

// File: logic/afecs_dmem.sv
/*
 * Engine data memory, one write and one registered read port.
 * Assumes the caller arbitrates by time slot.
 */
`timescale 1ns/1ps
module afecs_dmem
    import afecs_pkg::*;
#(
    parameter int unsigned WORDS = DMEM_WORDS
)
(
    // clock
    input wire logic clk_i,
    // write port
    input wire logic we_i,
    input wire logic [DMEM_AW-1:0] waddr_i,
    input wire logic [31:0] wdata_i,
    // read port
    input wire logic [DMEM_AW-1:0] raddr_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem_ff [WORDS];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
            mem_ff[waddr_i] <= wdata_i;
    end

    always_ff @(posedge clk_i)
    begin
        rdata_o <= mem_ff[raddr_i];
    end
endmodule // afecs_dmem

// File: logic/afecs_seq.sv
/*
 * Converter sequencer: frames, conversions, chopper, monitor, engine, flash.
 * Assumes inputs synchronous to clk_i; processor holds req until ack.
 */
`timescale 1ns/1ps

// Summary of operation
// - result 21 bits at select 0, 22 bits at 1
// - conversion takes two base ticks at select 0, three at 1
// - sequencer starts conversions; result to word of selection
// - result lsb-justified, shifted left nine
// - chopper field 0x2002[5:4]: positive, reverse, chop
// - positive holds swap low, reverse high
// - one settle tick after last state; swap set at its start
// - frame sync high in settle; its rise starts engine pass
// - pass starts with serial readout of four monitor words
// - chop toggles swap per frame, not at end of a sum
// - battery enable: alternate frame fills word 07
// - battery enable forced zero without main supply
// - words 00-03 phases, 06 temperature, 07 battery
// - pass starts as settle begins, ends on halt
// - fetch address 1024 times code location, two per word
// - flash shared between engine and processor
// - memory slots for filter, monitor, processor; byte holding
// - engine memory 128 words of 32 bits
// - two-level accumulation of samples, then of stage sums
// - accumulation done raises a pulse
// - regular frame phase inputs; alternate temperature first, battery last
// - alternate request edge gives one alternate frame next
// - sequencer steps on 32768 Hz base tick from divider
module afecs_seq #(
    parameter int unsigned BASE_DIV_P = afecs_pkg::BASE_DIV
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // processor port
    input wire logic cpu_req_i,
    input wire logic cpu_we_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic [7:0] cpu_rdata_o,
    output logic cpu_ack_o,
    // converter
    input wire logic [21:0] adc_data_i,
    input wire logic main_supply_ok_i,
    output logic adc_start_o,
    output logic adc_res_o,
    output logic [2:0] mux_sel_o,
    output logic batt_load_o,
    output logic amp_swap_o,
    output logic frame_sync_o,
    // compute engine
    input wire logic engine_halt_i,
    input wire logic engine_fetch_i,
    input wire logic [9:0] engine_pc_i,
    input wire logic [27:0] mon_sel_i,
    output logic engine_start_o,
    output logic engine_busy_o,
    output logic live_monitor_o,
    output logic accumulation_done_irq_o,
    // flash share
    input wire logic cpu_flash_req_i,
    input wire logic [14:0] cpu_flash_addr_i,
    output logic [14:0] flash_addr_o,
    output logic flash_rd_o,
    output logic engine_grant_o,
    output logic cpu_flash_grant_o
);
    import afecs_pkg::*;

    afecs_seq_t seq_ff;
    afecs_mon_t mon_ff;
    logic tick, res_ff, alt_req_ff, alt_req_d_ff, alt_pend_ff, alt_run_ff, batt_en_ff;
    logic conv_res_ff, sum_end, wr_pend_ff, cpu_busy_ff, cpu_rd_wait_ff, batt_eff;
    logic is_dmem, cpu_take, mem_we, cpu_commit, cpu_fetch, mon_fetch;
    logic [1:0] chop_ff, fs_code_ff, mux_st_ff, conv_tick_ff, slot_ff, mon_word_ff;
    logic [4:0] code_loc_ff;
    logic [5:0] ss_n_ff, ss_cnt_ff, mon_bit_ff;
    logic [6:0] fs_cnt_ff, wr_addr_ff, mem_waddr, mem_raddr, mon_addr, cur_word;
    logic [12:0] div_ff;
    logic [31:0] wr_data_ff, hold_ff, mem_wdata, mem_rdata;
    logic [34:0] mon_sh_ff;

    assign tick = (div_ff == 13'(BASE_DIV_P - 1));
    assign batt_eff = batt_en_ff & main_supply_ok_i;
    assign cur_word = frame_word(alt_run_ff, mux_st_ff);
    assign is_dmem = cpu_addr_i <= ADDR_DMEM_END;
    assign cpu_take = cpu_req_i & ~cpu_busy_ff & ~cpu_ack_o;
    assign cpu_commit = cpu_busy_ff & ~cpu_rd_wait_ff & cpu_we_i & (slot_ff == SLOT_CPU);
    assign cpu_fetch = cpu_busy_ff & ~cpu_rd_wait_ff & ~cpu_we_i & (slot_ff == SLOT_CPU);
    assign mon_fetch = (mon_ff == AFECS_MFETCH) & (slot_ff == SLOT_MON);
    assign mon_addr = mon_sel_i[7*mon_word_ff +: 7];
    assign sum_end = (fs_cnt_ff + 7'd1 >= first_stage_n(fs_code_ff));

    // memory port per slot, so no two agents ever meet on one port
    always_comb
    begin
        mem_we = 1'b0;
        mem_waddr = wr_addr_ff;
        mem_wdata = wr_data_ff;
        if (slot_ff == SLOT_FILT && wr_pend_ff)
            mem_we = 1'b1;
        else if (cpu_commit)
        begin
            mem_we = 1'b1;
            mem_waddr = cpu_addr_i[8:2];
            mem_wdata = {hold_ff[31:8], cpu_wdata_i};
        end
        mem_raddr = mon_fetch ? mon_addr : cpu_addr_i[8:2];
    end

    afecs_dmem #(
        .WORDS(DMEM_WORDS)
    ) u_dmem (
        .clk_i(clk_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i || tick)
            div_ff <= 13'h0000;
        else
            div_ff <= div_ff + 13'h0001;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || slot_ff == SLOT_CPU)
            slot_ff <= SLOT_FILT;
        else
            slot_ff <= slot_ff + 2'h1;
    end

    // processor registers and engine memory access
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chop_ff <= RST_CHOP;
            res_ff <= RST_RES;
            fs_code_ff <= RST_FS;
            ss_n_ff <= RST_SS;
            code_loc_ff <= RST_CODE;
            {alt_req_ff, batt_en_ff, cpu_busy_ff, cpu_rd_wait_ff, cpu_ack_o} <= 5'h0;
            {hold_ff, cpu_rdata_o} <= 40'h0;
        end
        else
        begin
            cpu_ack_o <= 1'b0;
            if (cpu_take && is_dmem)
            begin
                if (cpu_we_i && cpu_addr_i[1:0] != 2'h3)
                begin
                    hold_ff[8*(3 - cpu_addr_i[1:0]) +: 8] <= cpu_wdata_i;
                    cpu_ack_o <= 1'b1;
                end
                else
                    cpu_busy_ff <= 1'b1;
            end
            else if (cpu_take)
            begin
                cpu_ack_o <= 1'b1;
                cpu_rdata_o <= 8'h00;
                if (cpu_we_i && cpu_addr_i == ADDR_ACCUM)
                begin
                    fs_code_ff <= cpu_wdata_i[ACC_FS_LSB +: 2];
                    ss_n_ff <= cpu_wdata_i[5:0];
                end
                else if (cpu_we_i && cpu_addr_i == ADDR_CHOP)
                    chop_ff <= cpu_wdata_i[CHOP_LSB +: 2];
                else if (cpu_we_i && cpu_addr_i == ADDR_CONV)
                begin
                    res_ff <= cpu_wdata_i[CONV_RES_BIT];
                    alt_req_ff <= cpu_wdata_i[CONV_ALT_BIT];
                end
                else if (cpu_we_i && cpu_addr_i == ADDR_CODE)
                    code_loc_ff <= cpu_wdata_i[4:0];
                else if (cpu_we_i && cpu_addr_i == ADDR_BATT)
                    batt_en_ff <= cpu_wdata_i[BATT_EN_BIT];
                else if (cpu_addr_i == ADDR_ACCUM)
                    cpu_rdata_o <= {fs_code_ff, ss_n_ff};
                else if (cpu_addr_i == ADDR_CHOP)
                    cpu_rdata_o <= {2'h0, chop_ff, 4'h0};
                else if (cpu_addr_i == ADDR_CONV)
                    cpu_rdata_o <= {4'h0, alt_run_ff, alt_pend_ff, alt_req_ff, res_ff};
                else if (cpu_addr_i == ADDR_CODE)
                    cpu_rdata_o <= {3'h0, code_loc_ff};
                else if (cpu_addr_i == ADDR_BATT)
                    cpu_rdata_o <= {1'b0, batt_en_ff, 6'h00};
            end
            else if (cpu_commit)
            begin
                cpu_busy_ff <= 1'b0;
                cpu_ack_o <= 1'b1;
            end
            else if (cpu_fetch)
                cpu_rd_wait_ff <= 1'b1;
            else if (cpu_rd_wait_ff)
            begin
                cpu_rd_wait_ff <= 1'b0;
                cpu_busy_ff <= 1'b0;
                cpu_ack_o <= 1'b1;
                hold_ff <= mem_rdata;
                cpu_rdata_o <= mem_rdata[8*(3 - cpu_addr_i[1:0]) +: 8];
            end
        end
    end

    // alternate frame request: edge caught, served by exactly one frame
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            alt_req_d_ff <= 1'b0;
            alt_pend_ff <= 1'b0;
        end
        else
        begin
            alt_req_d_ff <= alt_req_ff;
            if (alt_req_ff && !alt_req_d_ff)
                alt_pend_ff <= 1'b1;
            else if (tick && seq_ff == AFECS_SETTLE)
                alt_pend_ff <= 1'b0;
        end
    end

    // frame sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            seq_ff <= AFECS_SETTLE;
            mux_st_ff <= 2'h3;
            conv_res_ff <= RST_RES;
            frame_sync_o <= 1'b1;
            {alt_run_ff, adc_start_o, wr_pend_ff, conv_tick_ff} <= 5'h0;
            {wr_addr_ff, wr_data_ff} <= 39'h0;
        end
        else
        begin
            adc_start_o <= 1'b0;
            if (slot_ff == SLOT_FILT)
                wr_pend_ff <= 1'b0;
            if (tick)
            begin
                case (seq_ff)
                    AFECS_CONV:
                    begin
                        conv_tick_ff <= conv_tick_ff + 2'h1;
                        if (conv_tick_ff == conv_ticks(conv_res_ff) - 2'h1)
                        begin
                            conv_tick_ff <= 2'h0;
                            if (!(alt_run_ff && mux_st_ff == 2'h3 && !batt_eff))
                            begin
                                wr_pend_ff <= 1'b1;
                                wr_addr_ff <= cur_word;
                                wr_data_ff <= place_result(adc_data_i, conv_res_ff);
                            end
                            if (mux_st_ff == 2'h3)
                            begin
                                seq_ff <= AFECS_SETTLE;
                                frame_sync_o <= 1'b1;
                            end
                            else
                            begin
                                mux_st_ff <= mux_st_ff + 2'h1;
                                adc_start_o <= 1'b1;
                                conv_res_ff <= res_ff;
                            end
                        end
                    end
                    default:
                    begin
                        seq_ff <= AFECS_CONV;
                        frame_sync_o <= 1'b0;
                        mux_st_ff <= 2'h0;
                        alt_run_ff <= alt_pend_ff;
                        adc_start_o <= 1'b1;
                        conv_res_ff <= res_ff;
                    end
                endcase
            end
        end
    end

    // input selection, battery load, swap and accumulation
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mux_sel_o <= 3'h0;
            adc_res_o <= RST_RES;
            {batt_load_o, amp_swap_o, accumulation_done_irq_o} <= 3'h0;
            {fs_cnt_ff, ss_cnt_ff} <= 13'h0;
        end
        else
        begin
            mux_sel_o <= cur_word[2:0];
            adc_res_o <= conv_res_ff;
            batt_load_o <= batt_eff & alt_run_ff;
            accumulation_done_irq_o <= 1'b0;
            if (tick && seq_ff == AFECS_CONV && mux_st_ff == 2'h3
                && conv_tick_ff == conv_ticks(conv_res_ff) - 2'h1)
            begin
                if (chop_ff == CHOP_POS)
                    amp_swap_o <= 1'b0;
                else if (chop_ff == CHOP_REV)
                    amp_swap_o <= 1'b1;
                else if (!sum_end)
                    amp_swap_o <= ~amp_swap_o;
                fs_cnt_ff <= fs_cnt_ff + 7'h01;
                if (sum_end)
                begin
                    fs_cnt_ff <= 7'h00;
                    ss_cnt_ff <= ss_cnt_ff + 6'h01;
                    if (ss_cnt_ff + 6'h01 >= ss_n_ff)
                    begin
                        ss_cnt_ff <= 6'h00;
                        accumulation_done_irq_o <= 1'b1;
                    end
                end
            end
        end
    end

    // live monitor readout, then engine pass
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mon_ff <= AFECS_MIDLE;
            {mon_word_ff, mon_bit_ff, mon_sh_ff} <= 43'h0;
            {live_monitor_o, engine_start_o, engine_busy_o} <= 3'h0;
        end
        else
        begin
            engine_start_o <= 1'b0;
            if (engine_halt_i)
                engine_busy_o <= 1'b0;
            case (mon_ff)
                AFECS_MIDLE:
                begin
                    live_monitor_o <= 1'b0;
                    if (tick && seq_ff == AFECS_CONV && mux_st_ff == 2'h3
                        && conv_tick_ff == conv_ticks(conv_res_ff) - 2'h1)
                    begin
                        mon_ff <= AFECS_MFETCH;
                        mon_word_ff <= 2'h0;
                    end
                end
                AFECS_MFETCH:
                begin
                    if (mon_fetch)
                        mon_ff <= AFECS_MLOAD;
                end
                AFECS_MLOAD:
                begin
                    mon_sh_ff <= {1'b1, mem_rdata, 2'h0};
                    mon_bit_ff <= 6'h00;
                    mon_ff <= AFECS_MSHIFT;
                end
                default:
                begin
                    live_monitor_o <= mon_sh_ff[MON_BITS-1];
                    mon_sh_ff <= {mon_sh_ff[33:0], 1'b0};
                    mon_bit_ff <= mon_bit_ff + 6'h01;
                    if (mon_bit_ff == 6'(MON_BITS - 1))
                    begin
                        mon_word_ff <= mon_word_ff + 2'h1;
                        mon_ff <= AFECS_MFETCH;
                        if (mon_word_ff == 2'(MON_WORDS - 1))
                        begin
                            mon_ff <= AFECS_MIDLE;
                            engine_start_o <= 1'b1;
                            engine_busy_o <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // flash share: engine fetches win, processor waits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            {flash_addr_o, flash_rd_o, engine_grant_o, cpu_flash_grant_o} <= 18'h0;
        end
        else
        begin
            flash_rd_o <= engine_fetch_i | cpu_flash_req_i;
            engine_grant_o <= engine_fetch_i;
            cpu_flash_grant_o <= cpu_flash_req_i & ~engine_fetch_i;
            if (engine_fetch_i)
                flash_addr_o <= {code_loc_ff, engine_pc_i[8:0], 1'b0};
            else
                flash_addr_o <= cpu_flash_addr_i;
        end
    end
endmodule // afecs_seq

// File: tb/afecs_seq_asserts.sv
/* port checker for afecs_seq: frame, conversion, swap, flash timing
   bound from the bench top file; sees only top module ports */
`timescale 1ns/1ps
module afecs_seq_asserts (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched ports
    input wire logic adc_start_o,
    input wire logic adc_res_o,
    input wire logic [2:0] mux_sel_o,
    input wire logic amp_swap_o,
    input wire logic frame_sync_o,
    input wire logic live_monitor_o,
    input wire logic engine_start_o,
    input wire logic accumulation_done_irq_o,
    input wire logic engine_fetch_i,
    input wire logic [9:0] engine_pc_i,
    input wire logic [14:0] flash_addr_o,
    input wire logic engine_grant_o
);
    logic [9:0] pc_ff;
    always_ff @(posedge clk_i) pc_ff <= engine_pc_i;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // flag bit follows the fetch gap
    sequence s_flag;
        ##[1:8] live_monitor_o;
    endsequence
    AST_START_PULSE: assert property (adc_start_o |=> !adc_start_o [*8])
        else $error("starts too close");
    AST_RES_LATCH: assert property ($changed(adc_res_o) |-> $past(adc_start_o))
        else $error("resolution changed mid conversion");
    AST_MUX_CODE: assert property (mux_sel_o != 3'h4 && mux_sel_o != 3'h5)
        else $error("unused select code");
    AST_SWAP_SETTLE: assert property ($changed(amp_swap_o) |-> frame_sync_o)
        else $error("swap moved outside settle");
    AST_SYNC_HOLD: assert property ($rose(frame_sync_o) |-> frame_sync_o [*8])
        else $error("frame sync short");
    AST_MON_FLAG: assert property ($rose(frame_sync_o) |-> s_flag)
        else $error("no monitor readout");
    AST_ENGINE_START: assert property (engine_start_o |-> frame_sync_o)
        else $error("pass start outside settle");
    AST_ENG_FLASH: assert property (engine_fetch_i |=> engine_grant_o
        && flash_addr_o[9:0] == {pc_ff[8:0], 1'b0})
        else $error("engine fetch wrong");
    AST_IRQ: assert property (accumulation_done_irq_o |-> frame_sync_o ##1
        !accumulation_done_irq_o)
        else $error("done pulse wrong");
endmodule // afecs_seq_asserts

// File: tb/afecs_engine_model.sv
/* behavioural compute engine: fetches and halts after each pass start
   slow_i picks a long pass; still ends well inside one frame */
`timescale 1ns/1ps
module afecs_engine_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // sequencer side
    input wire logic start_i,
    input wire logic slow_i,
    output logic halt_o,
    output logic fetch_o,
    output logic [9:0] pc_o
);
    int left = 0;
    initial pc_o = 10'h000;
    always @(posedge clk_i)
    begin
        halt_o <= 1'b0;
        fetch_o <= 1'b0;
        if (rst_i)
            left <= 0;
        else if (start_i)
        begin
            left <= slow_i ? 60 : 6;
            pc_o <= 10'h000;
        end
        else if (left > 0)
        begin
            left <= left - 1;
            fetch_o <= left[0];
            pc_o <= pc_o + 10'(left[0]);
            halt_o <= (left == 1);
        end
    end
endmodule // afecs_engine_model

// File: tb/test_afe_conversion_sequencer.sv
/* bench for afecs_seq with engine model
   needs afecs_pkg first; short base divider */
`timescale 1ns/1ps
module test_afe_conversion_sequencer;
    import afecs_pkg::*;
    localparam int unsigned BD = 210;
    logic clk_i = 1'b0, rst_i = 1'b1, cpu_req_i = 1'b0, cpu_we_i = 1'b0;
    logic main_supply_ok_i = 1'b1, cpu_flash_req_i = 1'b0, slow = 1'b0;
    logic [15:0] cpu_addr_i = 16'h0000;
    logic [7:0] cpu_wdata_i = 8'h00, cpu_rdata_o, rb;
    logic [21:0] adc_data_i = 22'h000000, d1;
    logic [27:0] mon_sel_i = 28'h0000000;
    logic [14:0] cpu_flash_addr_i = 15'h0000, flash_addr_o;
    logic [9:0] engine_pc_i;
    logic [2:0] mux_sel_o;
    logic [31:0] wv;
    logic cpu_ack_o, adc_start_o, adc_res_o, batt_load_o, amp_swap_o, frame_sync_o;
    logic engine_halt_i, engine_fetch_i, engine_start_o, engine_busy_o, live_monitor_o;
    logic accumulation_done_irq_o, flash_rd_o, engine_grant_o, cpu_flash_grant_o;
    logic fs_q, sw_b, prev;
    int failures = 0, n_tests = 0, n_frames = 0, k, n, g;
    int seed = 32'h4FD2;
    always #2 clk_i = ~clk_i;
    afecs_seq #(.BASE_DIV_P(BD)) afecs_seq_inst (.*);
    afecs_engine_model afecs_engine_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .start_i(engine_start_o), .slow_i(slow), .halt_o(engine_halt_i),
        .fetch_o(engine_fetch_i), .pc_o(engine_pc_i));
    always @(posedge clk_i)
    begin
        fs_q <= frame_sync_o;
        if (!frame_sync_o)
            sw_b <= amp_swap_o;
        if (frame_sync_o && !fs_q && !rst_i)
            n_frames <= n_frames + 1;
        cpu_flash_req_i <= 1'($random(seed));
        cpu_flash_addr_i <= 15'($random(seed));
        slow <= 1'($random(seed));
    end
    function automatic logic [31:0] exp_of(input logic [21:0] d, input logic r);
        return (r ? {10'h000, d} : {11'h000, d[20:0]}) << 9;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic we, input logic [15:0] a, input logic [7:0] wd);
        int c;
        cpu_req_i <= 1'b1;
        cpu_we_i <= we;
        cpu_addr_i <= a;
        cpu_wdata_i <= wd;
        c = 0;
        do
        begin
            @(posedge clk_i);
            c++;
        end
        while (cpu_ack_o !== 1'b1 && c < 40);
        rb = cpu_rdata_o;
        cpu_req_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd_word(input int w);
        for (int b = 0; b < 4; b++)
        begin
            bus(1'b0, 16'(w * 4 + b), 8'h00);
            wv = {wv[23:0], rb};
        end
    endtask
    task automatic frames(input int f);
        int t0;
        t0 = n_frames;
        g = 0;
        while (n_frames < t0 + f && g < 12000)
        begin
            @(posedge clk_i);
            g++;
        end
        failures += int'(g >= 12000);
        repeat (8) @(posedge clk_i);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        mon_sel_i <= 28'($random(seed));
        bus(1'b0, ADDR_CHOP, 8'h00);
        check("chop reset", rb, {2'h0, RST_CHOP, 4'h0});
        bus(1'b0, ADDR_CONV, 8'h00);
        check("conv reset", rb, {7'h00, RST_RES});
        bus(1'b1, 16'h3000, 8'h5A);
        bus(1'b0, 16'h3000, 8'h00);
        check("unmapped read", rb, 0);
        bus(1'b1, ADDR_ACCUM, 8'h01);
        bus(1'b1, ADDR_CODE, 8'h05);
        for (k = 0; k < 2; k++)
        begin
            bus(1'b1, ADDR_CHOP, 8'(k * 16));
            frames(2);
            check("swap level", amp_swap_o, k);
        end
        bus(1'b1, ADDR_CHOP, 8'h20);
        frames(1);
        prev = amp_swap_o;
        frames(1);
        check("swap toggle", amp_swap_o, !prev);
        $display("test chopper done");
        g = 0;
        while (engine_grant_o !== 1'b1 && g < 9000)
        begin
            @(posedge clk_i);
            g++;
        end
        failures += int'(g >= 9000);
        check("code location", flash_addr_o[14:10], 5'h05);
        for (k = 0; k < 2; k++)
        begin
            d1 = 22'($random(seed));
            adc_data_i <= d1;
            bus(1'b1, ADDR_CONV, 8'(k));
            frames(2);
            for (n = 0; n < 4; n++)
            begin
                rd_word(n);
                check("result word", wv, exp_of(d1, k[0]));
            end
            g = 0;
            while (!(adc_start_o === 1'b1 && mux_sel_o === 3'h0) && g < 9000)
            begin
                @(posedge clk_i);
                g++;
            end
            failures += int'(g >= 9000);
            n = 0;
            do
            begin
                @(posedge clk_i);
                n++;
            end
            while (adc_start_o !== 1'b1 && n < 2000);
            check("conversion length", n, (2 + k) * BD);
        end
        $display("test conversion done");
        bus(1'b1, ADDR_BATT, 8'h40);
        for (k = 0; k < 2; k++)
        begin
            main_supply_ok_i <= (k == 0);
            adc_data_i <= 22'($random(seed)) ^ {22{k[0]}};
            bus(1'b1, ADDR_CONV, 8'h00);
            bus(1'b1, ADDR_CONV, 8'h02);
            frames(3);
            rd_word(6);
            check("temperature word", wv, exp_of(adc_data_i, 1'b0));
            if (k == 0)
                d1 = adc_data_i;
            rd_word(7);
            check("battery word", wv, exp_of(d1, 1'b0));
        end
        $display("test alternate done");
        g = 0;
        while (accumulation_done_irq_o !== 1'b1 && g < 100000)
        begin
            @(posedge clk_i);
            g++;
        end
        failures += int'(g >= 100000);
        @(posedge clk_i);
        check("frames per sum", n_frames, 42);
        check("sum end swap", amp_swap_o, sw_b);
        $display("test accumulation done");
        stop_test;
    end
    initial
    begin
        repeat (130000) @(posedge clk_i);
        failures++;
        stop_test;
    end
endmodule // test_afe_conversion_sequencer
bind afecs_seq afecs_seq_asserts afecs_seq_asserts_inst (.*);
